// [pm_irq_cause_regs.v]
// Power manager interrupt, status, power control and cause register bank on the peripheral bus
`include "pm_regs_map.vh"

module pm_irq_cause_regs (
  // Clock and reset
  input wire sys_clk_i,
  input wire rst_n_i,
  // Peripheral bus slave
  input wire psel_i,
  input wire penable_i,
  input wire pwrite_i,
  input wire [9:0] paddr_i,
  input wire [31:0] pwdata_i,
  output reg [31:0] prdata_o,
  output wire pready_o,
  output wire pslverr_o,
  // Clock system events
  input wire clk_select_written_i,
  input wire clk_switch_done_i,
  input wire main_clock_fail_i,
  output reg main_clk_fallback_o,
  // Wake and reset cause sources
  input wire wake_event_i,
  input wire [31:0] wake_cause_i,
  input wire [31:0] reset_cause_i,
  // Flash power-up and wake-up gating
  input wire core_bod_ready_i,
  input wire bandgap_ready_i,
  output reg flash_powerup_go_o,
  output reg flash_wakeup_go_o,
  // Peripheral power control outputs
  output reg reset_pin_pullup_enable_o,
  output reg [7:0] request_clock_enable_o,
  output reg flash_skip_bandgap_wait_o,
  output reg flash_skip_core_brownout_wait_o,
  // Interrupt request
  output reg irq_o
);

  reg [31:0] mask_q;
  reg [31:0] mask_d;
  reg [31:0] pending_q;
  reg [31:0] pending_d;
  reg [31:0] ppc_q;
  reg [31:0] ppc_d;
  reg [31:0] reset_source_q;
  reg [31:0] wake_source_q;
  reg cause_taken_q;
  reg unlock_armed_q;
  reg unlock_armed_d;
  reg [9:0] unlock_addr_q;
  reg [9:0] unlock_addr_d;
  reg clk_ready_q;
  reg clk_ready_d;
  reg clk_fail_q;
  reg [31:0] raw_flags;
  reg [31:0] events;
  reg [31:0] rdata_d;
  wire access;
  wire wr;
  wire unlock_wr;
  wire prot_wr;
  wire prot_ok;

  // Zero-wait slave; no access is ever refused with an error
  assign pready_o = 1'b1;
  assign pslverr_o = 1'b0;

  // Transfer completes in the access phase
  assign access = psel_i & penable_i;
  assign wr = access & pwrite_i;
  assign unlock_wr = wr & (paddr_i == `OFS_UNLOCK);
  assign prot_wr = wr & (paddr_i == `OFS_PERIPHERAL_POWER_CONTROL);
  // A protected write passes only straight after an unlock naming it
  assign prot_ok = prot_wr & unlock_armed_q & (unlock_addr_q == paddr_i);

  // Write strobe of one register, selected by register offset
  function wr_hit;
    input [9:0] ofs;
    begin
      wr_hit = wr & (paddr_i == ofs);
    end
  endfunction

  // Ones in the written word clear the matching bits; zeros leave them alone
  function [31:0] clear_ones;
    input [31:0] old;
    input [31:0] ones;
    begin
      clear_ones = old & ~ones;
    end
  endfunction

  // Ones set the matching bits; shared by enable writes and event capture
  function [31:0] set_ones;
    input [31:0] old;
    input [31:0] ones;
    begin
      set_ones = old | ones;
    end
  endfunction

  // Unlock state: arms on a keyed write, dropped by any other access
  always @* begin
    unlock_armed_d = unlock_armed_q;
    unlock_addr_d = unlock_addr_q;
    if (unlock_wr) begin
      // Wrong key leaves the lock closed
      unlock_armed_d = (pwdata_i[`UNLOCK_KEY_MSB:`UNLOCK_KEY_LSB] == `UNLOCK_KEY);
      unlock_addr_d = pwdata_i[`UNLOCK_ADDR_MSB:0];
    end else if (access) begin
      unlock_armed_d = 1'b0;
    end
  end

  // Clock ready level: low from a select write until the switch is done
  always @* begin
    clk_ready_d = clk_ready_q;
    if (clk_switch_done_i) begin
      clk_ready_d = 1'b1;
    end
    if (clk_select_written_i) begin
      // A new select restarts the wait even if done arrives together
      clk_ready_d = 1'b0;
    end
  end

  // Events that set pending bits this cycle
  always @* begin
    events = 32'h00000000;
    events[`BIT_ACCESS_ERROR] = prot_wr & ~prot_ok;
    events[`BIT_WAKE] = wake_event_i;
    events[`BIT_CLOCK_READY] = clk_ready_d & ~clk_ready_q;
    events[`BIT_CLOCK_FAILURE] = main_clock_fail_i & ~clk_fail_q;
  end

  // Mask and pending updates; a new event beats a clear in the same cycle
  always @* begin
    mask_d = mask_q;
    pending_d = pending_q;
    if (wr_hit(`OFS_IRQ_ENABLE_SET)) begin
      mask_d = set_ones(mask_d, pwdata_i & `IRQ_IMPL_MASK);
    end
    if (wr_hit(`OFS_IRQ_ENABLE_CLEAR)) begin
      mask_d = clear_ones(mask_d, pwdata_i);
    end
    if (wr_hit(`OFS_IRQ_PENDING_CLEAR)) begin
      pending_d = clear_ones(pending_d, pwdata_i);
    end
    pending_d = set_ones(pending_d, events);
  end

  // Power control register accepts writes only through the unlock
  always @* begin
    ppc_d = ppc_q;
    if (prot_ok) begin
      ppc_d = pwdata_i & `PPC_IMPL_MASK;
    end
  end

  // Status flags, independent of the mask; error and wake bits mirror pending
  always @* begin
    raw_flags = 32'h00000000;
    raw_flags[`BIT_ACCESS_ERROR] = pending_q[`BIT_ACCESS_ERROR];
    raw_flags[`BIT_WAKE] = pending_q[`BIT_WAKE];
    raw_flags[`BIT_CLOCK_READY] = clk_ready_q;
    raw_flags[`BIT_CLOCK_FAILURE] = clk_fail_q;
  end

  // Read mux; write-only and unmapped offsets read zero
  always @* begin
    rdata_d = 32'h00000000;
    case (paddr_i)
      `OFS_IRQ_MASK_VIEW: rdata_d = mask_q;
      `OFS_IRQ_PENDING: rdata_d = pending_q;
      `OFS_RAW_STATUS_FLAGS: rdata_d = raw_flags;
      `OFS_PERIPHERAL_POWER_CONTROL: rdata_d = ppc_q;
      `OFS_RESET_SOURCE: rdata_d = reset_source_q;
      `OFS_WAKE_SOURCE: rdata_d = wake_source_q;
      default: rdata_d = 32'h00000000;
    endcase
  end

  // Interrupt enables; only the set and clear registers move them
  always @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      mask_q <= `IRQ_RESET;
    end else begin
      // Next value already merges set and clear writes
      mask_q <= mask_d;
    end
  end

  // Pending flags; sticky until software writes ones to the clear register
  always @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pending_q <= `IRQ_RESET;
    end else begin
      // A new event beats a clear landing in the same cycle
      pending_q <= pending_d;
    end
  end

  // Power control word; starts with every request clock enabled
  always @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ppc_q <= `PPC_RESET;
    end else begin
      // Changes only through an unlocked write
      ppc_q <= ppc_d;
    end
  end

  // Unlock flag; cleared by reset so a stale key never carries over
  always @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      unlock_armed_q <= 1'b0;
    end else begin
      // Lives for one access only
      unlock_armed_q <= unlock_armed_d;
    end
  end

  // Address named by the last unlock write
  always @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      unlock_addr_q <= 10'h000;
    end else begin
      // Only meaningful while the unlock flag is set
      unlock_addr_q <= unlock_addr_d;
    end
  end

  // Clock ready level; the clock running out of reset counts as settled
  always @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      clk_ready_q <= 1'b1;
    end else begin
      // A select write wins over a done in the same cycle
      clk_ready_q <= clk_ready_d;
    end
  end

  // Failure latch; holds until reset since the main clock is abandoned
  always @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      clk_fail_q <= 1'b0;
    end else begin
      // No software clear: a failed clock is never trusted again
      clk_fail_q <= clk_fail_q | main_clock_fail_i;
    end
  end

  // Read data registered in the setup phase so it is stable in the access phase
  always @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      prdata_o <= 32'h00000000;
    end else if (psel_i & ~penable_i & ~pwrite_i) begin
      // Held between reads; a write leaves the last read word in place
      prdata_o <= rdata_d;
    end
  end

  // Reset-time cause capture runs once, on the first edge after reset release
  always @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cause_taken_q <= 1'b0;
    end else begin
      // Stays set until the next reset
      cause_taken_q <= 1'b1;
    end
  end

  // Reset source strap; later changes of the strap are ignored until reset
  always @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      reset_source_q <= 32'h00000000;
    end else if (!cause_taken_q) begin
      // Bits 0,1,2,3,6,8,10,13
      reset_source_q <= reset_cause_i & `RESET_SOURCE_MASK;
    end
  end

  // Wake source; the newest wake overwrites the older cause
  always @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wake_source_q <= 32'h00000000;
    end else if (!cause_taken_q) begin
      wake_source_q <= wake_cause_i & `WAKE_SOURCE_MASK;
    end else if (wake_event_i) begin
      wake_source_q <= wake_cause_i & `WAKE_SOURCE_MASK;
    end
  end

  // Interrupt request; one cycle behind pending and mask, free of glitches
  always @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      irq_o <= 1'b0;
    end else begin
      // Level request, dropped once the cause is cleared or masked
      irq_o <= |(pending_q & mask_q);
    end
  end

  // Slow oscillator fallback follows the failure latch
  always @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      main_clk_fallback_o <= 1'b0;
    end else begin
      // Sticky like the latch it copies
      main_clk_fallback_o <= clk_fail_q;
    end
  end

  // Reset pin pull-up from power control bit 0
  always @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      reset_pin_pullup_enable_o <= 1'b0;
    end else begin
      // Off out of reset because the reset value leaves bit 0 clear
      reset_pin_pullup_enable_o <= ppc_q[`PPC_RESET_PULLUP];
    end
  end

  // Request clock enables, one bit per peripheral
  always @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      request_clock_enable_o <= 8'h00;
    end else begin
      // Touch in bit 0 up to regulator in bit 7
      request_clock_enable_o <= ppc_q[`PPC_REQ_CLK_MSB:`PPC_REQ_CLK_LSB];
    end
  end

  // Flash bandgap wait skip, exported as set
  always @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      flash_skip_bandgap_wait_o <= 1'b0;
    end else begin
      // High means the flash may resume without the bandgap
      flash_skip_bandgap_wait_o <= ppc_q[`PPC_SKIP_BANDGAP];
    end
  end

  // Flash core brown-out wait skip, exported as set
  always @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      flash_skip_core_brownout_wait_o <= 1'b0;
    end else begin
      // High means the flash may power up without the detector
      flash_skip_core_brownout_wait_o <= ppc_q[`PPC_SKIP_CORE_BOD];
    end
  end

  // Flash power-up gate; skipping the wait trades safety for start-up time
  always @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      flash_powerup_go_o <= 1'b0;
    end else begin
      // Proceeds when the wait is skipped or the detector is ready
      flash_powerup_go_o <= ppc_q[`PPC_SKIP_CORE_BOD] | core_bod_ready_i;
    end
  end

  // Flash wake-up gate; the bandgap must be ready unless the wait is skipped
  always @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      flash_wakeup_go_o <= 1'b0;
    end else begin
      // Proceeds when the wait is skipped or the bandgap is ready
      flash_wakeup_go_o <= ppc_q[`PPC_SKIP_BANDGAP] | bandgap_ready_i;
    end
  end

endmodule

// [pm_irq_cause_regs_asserts.sv]
// Port checker of the power manager register bank
module pm_irq_cause_regs_asserts (
  // Watched ports
  input wire sys_clk_i,
  input wire rst_n_i,
  input wire psel_i,
  input wire penable_i,
  input wire pwrite_i,
  input wire [9:0] paddr_i,
  input wire [31:0] pwdata_i,
  input wire main_clock_fail_i,
  input wire main_clk_fallback_o,
  input wire core_bod_ready_i,
  input wire bandgap_ready_i,
  input wire flash_powerup_go_o,
  input wire flash_wakeup_go_o,
  input wire reset_pin_pullup_enable_o,
  input wire [7:0] request_clock_enable_o,
  input wire flash_skip_bandgap_wait_o,
  input wire flash_skip_core_brownout_wait_o
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);
  // Power control outputs in register bit order
  wire [10:0] ppc_view = {flash_skip_core_brownout_wait_o, flash_skip_bandgap_wait_o,
    request_clock_enable_o, reset_pin_pullup_enable_o};
  wire acc = psel_i && penable_i;
  wire wr_ppc = acc && pwrite_i && paddr_i == 10'h160;
  reg armed_q;
  // Any access closes the unlock window, so only the very next one may use it
  always @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i)
      armed_q <= 1'b0;
    else if (acc)
      armed_q <= pwrite_i && paddr_i == 10'h058 && pwdata_i == 32'haa000160;
  end
  property p_unlock;
    wr_ppc && armed_q |-> ##2 ppc_view == $past(pwdata_i[10:0], 2);
  endproperty
  a_unlock: assert property (p_unlock) else $error("unlocked write lost");
  property p_locked;
    wr_ppc && !armed_q |=> ##1 $stable(ppc_view);
  endproperty
  a_locked: assert property (p_locked) else $error("locked write taken");
  property p_rst_val;
    !$past(rst_n_i) |=> ppc_view == 11'h1fe;
  endproperty
  a_rst_val: assert property (p_rst_val) else $error("bad power reset value");
  property p_bod_gate;
    $past(rst_n_i) |-> flash_powerup_go_o == (ppc_view[10] | $past(core_bod_ready_i));
  endproperty
  a_bod_gate: assert property (p_bod_gate) else $error("powerup gate wrong");
  property p_bg_gate;
    $past(rst_n_i) |-> flash_wakeup_go_o == (ppc_view[9] | $past(bandgap_ready_i));
  endproperty
  a_bg_gate: assert property (p_bg_gate) else $error("wakeup gate wrong");
  property p_fail_set;
    $rose(main_clock_fail_i) |-> ##[1:2] main_clk_fallback_o;
  endproperty
  a_fail_set: assert property (p_fail_set) else $error("no fallback");
  property p_fail_hold;
    main_clk_fallback_o |=> main_clk_fallback_o;
  endproperty
  a_fail_hold: assert property (p_fail_hold) else $error("fallback dropped");
  property p_pullup;
    !$stable(reset_pin_pullup_enable_o) |-> $past(wr_ppc && armed_q, 2);
  endproperty
  a_pullup: assert property (p_pullup) else $error("pull-up moved");
  c_unlock: cover property (wr_ppc && armed_q);
  c_locked: cover property (wr_ppc && !armed_q);
  c_fail: cover property ($rose(main_clock_fail_i));
endmodule
bind pm_irq_cause_regs pm_irq_cause_regs_asserts i_chk (.*);

// [pm_regs_map.vh]
// Register offsets, field positions and reset values of the power manager register bank
// Summary of operation
// - Next access writes named register, then relock
// - Enable-set ones set mask bits
// - Enable-clear ones clear mask bits
// - Mask view shows enables, resets zero
// - Pending bit sets on event, sticks
// - Pending-clear ones clear pending bits
// - Locked write raises access error bit 31
// - Wake event raises bit 8, cause recorded
// - Clock ready low from select write to done
// - Clock failure sets bit 0, fall back
// - Bit 10 low: flash waits core brownout
// - Bit 9 low: flash waits bandgap on wake
// - Bits 1-8 request clocks, reset 0x1fe
// - Bit 0 enables reset pin pull-up
// - Reset source bit 0 core power-on
// - Reset source bit 1 core brown-out
// - Bit 3 watchdog, bit 2 reset pin
// - Bit 8 processor software reset request
// - Bit 6 wake from backup mode
// - Bit 10 io power-on, 13 io brown-out
// - Wake source: 0-7 async, 16, 17
`ifndef PM_REGS_MAP_VH
`define PM_REGS_MAP_VH

// Register byte offsets
`define OFS_UNLOCK 10'h058
`define OFS_IRQ_ENABLE_SET 10'h0c0
`define OFS_IRQ_ENABLE_CLEAR 10'h0c4
`define OFS_IRQ_MASK_VIEW 10'h0c8
`define OFS_IRQ_PENDING 10'h0cc
`define OFS_IRQ_PENDING_CLEAR 10'h0d0
`define OFS_RAW_STATUS_FLAGS 10'h0d4
`define OFS_PERIPHERAL_POWER_CONTROL 10'h160
`define OFS_RESET_SOURCE 10'h180
`define OFS_WAKE_SOURCE 10'h184

// Unlock register fields
`define UNLOCK_KEY 8'haa
`define UNLOCK_KEY_MSB 31
`define UNLOCK_KEY_LSB 24
`define UNLOCK_ADDR_MSB 9

// Interrupt source bit positions
`define BIT_ACCESS_ERROR 31
`define BIT_WAKE 8
`define BIT_CLOCK_READY 5
`define BIT_CLOCK_FAILURE 0
`define IRQ_IMPL_MASK 32'h80000121

// Peripheral power control fields
`define PPC_RESET_PULLUP 0
`define PPC_REQ_CLK_LSB 1
`define PPC_REQ_CLK_MSB 8
`define PPC_SKIP_BANDGAP 9
`define PPC_SKIP_CORE_BOD 10
`define PPC_IMPL_MASK 32'h000007ff
`define PPC_RESET 32'h000001fe

// Implemented bits of the cause registers and the interrupt register reset value
`define RESET_SOURCE_MASK 32'h0000254f
`define WAKE_SOURCE_MASK 32'h000300ff
`define IRQ_RESET 32'h00000000

`endif

// [test_power_manager_irq_and_cause_regs.sv]
// Self-checking bench of the power manager register bank
module test_power_manager_irq_and_cause_regs;
  timeunit 1ns;
  timeprecision 1ps;
  // Bench drive and design outputs
  logic sys_clk_i = 0, rst_n_i = 0, psel_i = 0, penable_i = 0, pwrite_i = 0;
  logic clk_select_written_i = 0, clk_switch_done_i = 0, main_clock_fail_i = 0;
  logic wake_event_i = 0, core_bod_ready_i = 0, bandgap_ready_i = 0;
  logic [9:0] paddr_i = 0;
  logic [31:0] pwdata_i = 0, wake_cause_i = '1, reset_cause_i = '1, prdata_o, r;
  logic pready_o, pslverr_o, main_clk_fallback_o, flash_powerup_go_o, flash_wakeup_go_o, irq_o;
  logic reset_pin_pullup_enable_o, flash_skip_bandgap_wait_o, flash_skip_core_brownout_wait_o;
  logic [7:0] request_clock_enable_o;
  int n_fail = 0, checked = 0, cyc = 0;
  typedef struct {logic [9:0] wa; logic [31:0] wd; logic [9:0] ra; logic [31:0] ex;} row_t;
  // Write then read back; only the bits 31, 8, 5 and 0 exist in the mask
  row_t rows[5] = '{
    '{10'h0c0, 32'hffffffff, 10'h0c8, 32'h80000121},
    '{10'h0c4, 32'h00000100, 10'h0c8, 32'h80000021},
    '{10'h0c4, 32'h00000000, 10'h0c8, 32'h80000021},
    '{10'h0c8, 32'h00000000, 10'h0c8, 32'h80000021},
    '{10'h3fc, 32'hffffffff, 10'h3fc, 32'h00000000}};
  pm_irq_cause_regs i_dut (.*);
  always #2 sys_clk_i = ~sys_clk_i;
  // Cut a hang short well past the expected run length
  always @(posedge sys_clk_i) begin
    cyc++;
    if (cyc == 3000) begin
      n_fail++;
      report_and_stop;
    end
  end
  task automatic chk(input logic [31:0] ex, input logic [31:0] got, input string what);
    checked++;
    if (got !== ex) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", what, ex, got);
    end
  endtask
  // One bus transfer, setup then access, released at the next falling edge
  task automatic bus(input logic w, input logic [9:0] a, input logic [31:0] d);
    @(negedge sys_clk_i) psel_i = 1;
    pwrite_i = w;
    paddr_i = a;
    pwdata_i = d;
    @(negedge sys_clk_i) penable_i = 1;
    @(posedge sys_clk_i) r = prdata_o;
    @(negedge sys_clk_i) psel_i = 0;
    penable_i = 0;
  endtask
  task automatic rchk(input logic [9:0] a, input logic [31:0] ex, input string what);
    bus(0, a, 32'h0);
    chk(ex, r, what);
  endtask
  task automatic pulse(ref logic s);
    @(negedge sys_clk_i) s = 1;
    @(negedge sys_clk_i) s = 0;
  endtask
  task automatic reset_dut;
    @(negedge sys_clk_i) rst_n_i = 0;
    repeat (4) @(negedge sys_clk_i);
    rst_n_i = 1;
  endtask
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial begin
    reset_dut();
    foreach (rows[i]) begin
      bus(1, rows[i].wa, rows[i].wd);
      rchk(rows[i].ra, rows[i].ex, "table row");
    end
    $display("table done");
    reset_dut();
    rchk(10'h0c8, 32'h0, "mask after reset");
    rchk(10'h160, 32'h000001fe, "power control");
    rchk(10'h0d4, 32'h00000020, "raw status");
    rchk(10'h180, 32'h0000254f, "reset source");
    chk({flash_powerup_go_o, flash_wakeup_go_o, reset_pin_pullup_enable_o,
      request_clock_enable_o}, 32'h0ff, "power outputs");
    chk({pready_o, pslverr_o}, 32'h2, "bus response");
    @(negedge sys_clk_i) core_bod_ready_i = 1;
    bandgap_ready_i = 1;
    repeat (2) @(negedge sys_clk_i);
    chk({flash_powerup_go_o, flash_wakeup_go_o, flash_skip_bandgap_wait_o,
      flash_skip_core_brownout_wait_o}, 32'hc, "flash gates");
    core_bod_ready_i = 0;
    bandgap_ready_i = 0;
    $display("reset done");
    bus(1, 10'h058, 32'h55000160);
    bus(1, 10'h160, 32'h00000601);
    rchk(10'h160, 32'h000001fe, "wrong key");
    rchk(10'h0cc, 32'h80000000, "access error");
    bus(1, 10'h058, 32'haa000160);
    bus(0, 10'h160, 32'h0);
    bus(1, 10'h160, 32'h00000601);
    rchk(10'h160, 32'h000001fe, "read disarms");
    bus(1, 10'h0d0, 32'h80000000);
    bus(1, 10'h058, 32'haa000160);
    bus(1, 10'h160, 32'h00000601);
    rchk(10'h160, 32'h00000601, "unlocked write");
    rchk(10'h0cc, 32'h0, "error cleared");
    chk({flash_powerup_go_o, flash_wakeup_go_o, reset_pin_pullup_enable_o,
      request_clock_enable_o}, 32'h700, "power outputs");
    chk({flash_skip_bandgap_wait_o, flash_skip_core_brownout_wait_o}, 32'h3, "skips");
    $display("lock done");
    bus(1, 10'h0c0, 32'h80000121);
    pulse(wake_event_i);
    rchk(10'h184, 32'h000300ff, "wake source");
    rchk(10'h0cc, 32'h00000100, "wake pending");
    chk(irq_o, 32'h1, "irq");
    pulse(clk_select_written_i);
    rchk(10'h0d4, 32'h00000100, "clock busy");
    pulse(clk_switch_done_i);
    pulse(main_clock_fail_i);
    rchk(10'h0d4, 32'h00000121, "raw flags");
    bus(1, 10'h0c4, 32'h80000121);
    rchk(10'h0cc, 32'h00000121, "pending sticks");
    chk({irq_o, main_clk_fallback_o}, 32'h1, "masked irq");
    bus(1, 10'h0d0, 32'hffffffff);
    rchk(10'h0cc, 32'h0, "pending cleared");
    $display("events done");
    report_and_stop();
  end
endmodule
